// >>> rtl/flash_array.sv
// one flash array: storage, embedded program/erase, protection
`timescale 1ns/1ns
`default_nettype none
module flash_array
   import flash_cmd_pkg::*;
#(
   parameter int NSECT = 4,
   parameter int SECT_W = 8,
   parameter int PROG_CYC = PROG_CYC_DEF,
   parameter int ERASE_CYC = ERASE_CYC_DEF
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [NSECT-1:0] sel,
   input wire logic [SECT_W-1:0] addr,
   output logic [DATA_W-1:0] rdata,
   input wire logic start,
   input wire op_e op,
   input wire logic [NSECT-1:0] op_sect,
   input wire logic [SECT_W-1:0] op_addr,
   input wire logic [DATA_W-1:0] op_data,
   input wire logic suspend,
   input wire logic resume,
   input wire logic [NSECT-1:0] prot,
   output logic busy,
   output logic suspended,
   output logic [DATA_W-1:0] poll_data
);
   logic [DATA_W-1:0] mem [NSECT*(2**SECT_W)];
   op_e op_r;
   logic [NSECT-1:0] sect_r;
   logic [SECT_W-1:0] addr_r;
   logic [DATA_W-1:0] data_r;
   logic [CNT_W-1:0] cnt_r;
   logic susp_r;
   logic [$clog2(NSECT)-1:0] rsel;
   logic [$clog2(NSECT)-1:0] psel;
   logic [SECT_W:0] wipe_r;
   logic done;

   function automatic logic [$clog2(NSECT)-1:0] enc(input logic [NSECT-1:0] v);
      enc = '0;
      for (int i = NSECT - 1; i >= 0; i--) begin
         if (v[i]) begin
            enc = i[$clog2(NSECT)-1:0];
         end
      end
   endfunction

   assign rsel = enc(sel);
   assign psel = enc(sect_r);
   assign busy = (op_r != OP_NONE);
   assign suspended = susp_r;
   assign done = busy && !susp_r && (cnt_r == '0);
   // polling flag shows complement until done
   assign poll_data = (op_r == OP_PROG) ? {~data_r[POLL_BIT], data_r[POLL_BIT-1:0]} :
                      {1'b0, data_r[POLL_BIT-1:0]}; // R21

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         op_r <= OP_NONE;
         sect_r <= '0;
         addr_r <= '0;
         data_r <= '0;
         cnt_r <= '0;
         susp_r <= 1'b0;
      end else if (start && !busy) begin
         // protected sectors silently refuse
         if ((op_sect & prot) == '0 || op == OP_CERASE) begin // R13
            op_r <= op;
            sect_r <= (op == OP_CERASE) ? ~prot : op_sect;
            addr_r <= op_addr;
            data_r <= (op == OP_PROG) ? op_data : '0;
            cnt_r <= (op == OP_PROG) ? CNT_W'(PROG_CYC) : CNT_W'(ERASE_CYC);
         end
      end else if (suspend && op_r == OP_SERASE && !susp_r) begin
         susp_r <= 1'b1; // R12
      end else if (resume && susp_r) begin
         susp_r <= 1'b0; // R12
      end else if (done) begin
         op_r <= OP_NONE;
         data_r <= ERASED_BYTE;
      end else if (busy && !susp_r) begin
         cnt_r <= cnt_r - 1'b1;
      end
   end

   // erase wipes sector bytes one per cycle; programming only clears bits
   always_ff @(posedge clk) begin
      if (done && op_r == OP_PROG) begin
         mem[{psel, addr_r}] <= mem[{psel, addr_r}] & data_r; // R10
      end
      if (busy && !susp_r && op_r != OP_PROG && !wipe_r[SECT_W]) begin
         for (int s = 0; s < NSECT; s++) begin
            if (sect_r[s]) begin
               mem[{s[$clog2(NSECT)-1:0], wipe_r[SECT_W-1:0]}] <= ERASED_BYTE;
            end
         end
      end
      rdata <= mem[{rsel, addr}];
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wipe_r <= '0;
      end else if (start && !busy) begin
         wipe_r <= '0;
      end else if (busy && !susp_r && !wipe_r[SECT_W]) begin
         wipe_r <= wipe_r + 1'b1;
      end
   end
endmodule
`default_nettype wire

// >>> rtl/flash_cmd_pkg.sv
// constants for the flash command sequencer
package flash_cmd_pkg;
   localparam int ADDR_W = 16;
   localparam int DATA_W = 8;
   localparam int N_PRI = 4;
   localparam int N_SEC = 2;
   localparam int N_SECT = N_PRI + N_SEC;
   localparam int MATCH_W = 12;
   localparam logic [11:0] UNLOCK1_ADDR = 12'h555;
   localparam logic [11:0] UNLOCK2_ADDR = 12'haaa;
   localparam logic [7:0] UNLOCK1_DATA = 8'haa;
   localparam logic [7:0] UNLOCK2_DATA = 8'h55;
   localparam logic [7:0] CMD_PROT_READ = 8'h90;
   localparam logic [7:0] CMD_PROGRAM = 8'ha0;
   localparam logic [7:0] CMD_ERASE_SETUP = 8'h80;
   localparam logic [7:0] CMD_SECTOR_ERASE = 8'h30;
   localparam logic [7:0] CMD_CHIP_ERASE = 8'h10;
   localparam logic [7:0] CMD_SUSPEND = 8'hb0;
   localparam logic [7:0] CMD_RESUME = 8'h30;
   localparam logic [7:0] CMD_RESET = 8'hf0;
   localparam logic [7:0] PROT_YES = 8'h01;
   localparam logic [7:0] PROT_NO = 8'h00;
   localparam logic [1:0] PROT_READ_A10 = 2'h2;
   localparam logic [7:0] REG_PRI_PROT = 8'hc0;
   localparam logic [7:0] REG_SEC_PROT = 8'hc2;
   localparam int POLL_BIT = 7;
   localparam int TIMEOUT_CYC_DEF = 4000;
   localparam int PROG_CYC_DEF = 500;
   localparam int ERASE_CYC_DEF = 2000;
   localparam int CNT_W = 24;
   localparam logic [7:0] ERASED_BYTE = 8'hff;
   typedef enum logic [1:0] {OP_NONE, OP_PROG, OP_SERASE, OP_CERASE} op_e;
endpackage

// >>> rtl/flash_command_sequencer.sv
// command decoder and status for the dual flash arrays
//
// Notes on behaviour
// [R1] ready/busy pin low during program or erase
// [R2] flash writes are command steps, not data
// [R3] launch only after full, timely sequence
// [R4] bad byte or time-out returns read mode
// [R5] unlock AAh@555h then 55h@AAAh first
// [R6] upper address bits ignored in matching
// [R7] host asserts sector select on command writes
// [R8] primary or secondary selects route command
// [R9] same command set for both arrays
// [R10] lone write never changes stored data
// [R11] plain reads return stored byte
// [R12] sector erase, suspend and resume supported
// [R13] protected sectors refuse program and erase
// [R14] host polls status before trusting program
// [R15] chip, sector erase, suspend, resume, program, reset, protect
// [R16] protect-status read phase allows repeated reads
// [R17] protection registers at C0 and C2
// [R18] register offsets relative to window base
// [R19] protect read gives 01h or 00h
// [R20] read mode after reset or reset command
// [R21] polling bit complements programmed bit while busy
// [R22] time-out is a clock-count parameter
`timescale 1ns/1ns
`default_nettype none
module flash_command_sequencer
   import flash_cmd_pkg::*;
#(
   parameter int TIMEOUT_CYC = TIMEOUT_CYC_DEF,
   parameter int PROG_CYC = PROG_CYC_DEF,
   parameter int ERASE_CYC = ERASE_CYC_DEF
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [ADDR_W-1:0] addr,
   input wire logic [DATA_W-1:0] wdata,
   input wire logic wr,
   input wire logic rd,
   input wire logic [N_PRI-1:0] primary_sector_selects,
   input wire logic [N_SEC-1:0] secondary_sector_selects,
   input wire logic register_window_select,
   input wire logic [N_PRI-1:0] pri_prot_cfg,
   input wire logic [N_SEC-1:0] sec_prot_cfg,
   input wire logic security_cfg,
   output logic [DATA_W-1:0] rdata,
   output logic rvalid,
   output logic ready_busy_pin
);
   typedef enum logic [3:0] {
      S_READ, S_UNL1, S_UNL2, S_PROG_DATA, S_ERASE_UNL0, S_ERASE_UNL1,
      S_ERASE_UNL2, S_SECTOR_MORE, S_PROT_READ
   } seq_e;

   localparam int PRI_W = 14;
   localparam int SEC_W = 13;

   seq_e state_r, state_nxt;
   logic tgt_r, tgt_nxt;
   logic [CNT_W-1:0] tmo_r;
   logic [N_PRI-1:0] esect_pri_r, esect_pri_nxt;
   logic [N_SEC-1:0] esect_sec_r, esect_sec_nxt;
   logic rd_d_r, win_d_r, prot_d_r, poll_d_r, tgt_d_r;
   logic [DATA_W-1:0] prot_byte_r, poll_byte_r;

   logic pri_hit, sec_hit, flash_wr, flash_rd, tgt_now;
   logic [MATCH_W-1:0] low_addr;
   logic is_unl1, is_unl2, is_cmd_addr;
   logic timed_out;
   logic start_pri, start_sec, susp_cmd, resume_cmd;
   op_e op_sel;
   logic [N_PRI-1:0] op_sect_pri;
   logic [N_SEC-1:0] op_sect_sec;
   logic launch;
   logic [DATA_W-1:0] pri_rdata, sec_rdata, pri_poll, sec_poll, reg_rdata;
   logic pri_busy, sec_busy, pri_susp, sec_susp, reg_hit;
   logic tgt_busy, tgt_susp;

   function automatic logic match(input logic [MATCH_W-1:0] a, input logic [11:0] ref_a,
                                  input logic [7:0] d, input logic [7:0] ref_d);
      match = (a == ref_a) && (d == ref_d);
   endfunction

   assign pri_hit = |primary_sector_selects; // R8
   assign sec_hit = |secondary_sector_selects; // R8
   // writes without a sector select never reach the decoder
   assign flash_wr = wr && (pri_hit || sec_hit); // R7
   assign flash_rd = rd && (pri_hit || sec_hit);
   assign tgt_now = sec_hit && !pri_hit;
   assign low_addr = addr[MATCH_W-1:0]; // R6
   assign is_unl1 = match(low_addr, UNLOCK1_ADDR, wdata, UNLOCK1_DATA); // R5
   assign is_unl2 = match(low_addr, UNLOCK2_ADDR, wdata, UNLOCK2_DATA); // R5
   assign is_cmd_addr = (low_addr == UNLOCK1_ADDR);
   assign timed_out = (state_r != S_READ) && (tmo_r == CNT_W'(TIMEOUT_CYC)); // R22
   assign tgt_busy = tgt_now ? sec_busy : pri_busy;
   assign tgt_susp = tgt_now ? sec_susp : pri_susp;
   // single-byte suspend and resume only make sense against a sector erase
   assign susp_cmd = flash_wr && (state_r == S_READ) && wdata == CMD_SUSPEND
                     && tgt_busy && !tgt_susp; // R12
   assign resume_cmd = flash_wr && (state_r == S_READ) && wdata == CMD_RESUME
                       && tgt_susp; // R12

   always_comb begin
      state_nxt = state_r;
      tgt_nxt = tgt_r;
      esect_pri_nxt = esect_pri_r;
      esect_sec_nxt = esect_sec_r;
      op_sel = OP_NONE;
      launch = 1'b0;
      if (timed_out) begin
         state_nxt = S_READ; // R4
      end else if (flash_wr) begin
         state_nxt = S_READ; // R4
         case (state_r)
            S_READ: begin
               if (is_unl1) begin
                  state_nxt = S_UNL1; // R2 R5
                  tgt_nxt = tgt_now; // R9
               end
            end
            S_UNL1: begin
               if (is_unl2) begin
                  state_nxt = S_UNL2; // R5
               end
            end
            S_UNL2: begin
               if (is_cmd_addr && wdata == CMD_PROGRAM) begin
                  state_nxt = S_PROG_DATA; // R15
               end else if (is_cmd_addr && wdata == CMD_ERASE_SETUP) begin
                  state_nxt = S_ERASE_UNL0; // R15
               end else if (is_cmd_addr && wdata == CMD_PROT_READ) begin
                  state_nxt = S_PROT_READ; // R15 R16
               end
            end
            S_PROG_DATA: begin
               op_sel = OP_PROG;
               launch = 1'b1; // R3
            end
            S_ERASE_UNL0: begin
               if (is_unl1) begin
                  state_nxt = S_ERASE_UNL1;
               end
            end
            S_ERASE_UNL1: begin
               if (is_unl2) begin
                  state_nxt = S_ERASE_UNL2;
               end
            end
            S_ERASE_UNL2: begin
               if (is_cmd_addr && wdata == CMD_CHIP_ERASE) begin
                  op_sel = OP_CERASE;
                  launch = 1'b1; // R3 R15
               end else if (wdata == CMD_SECTOR_ERASE) begin
                  // collect sectors; erase launches when the time-out closes the list
                  state_nxt = S_SECTOR_MORE; // R12
                  esect_pri_nxt = primary_sector_selects;
                  esect_sec_nxt = secondary_sector_selects;
               end
            end
            S_SECTOR_MORE: begin
               if (wdata == CMD_SECTOR_ERASE) begin
                  state_nxt = S_SECTOR_MORE;
                  esect_pri_nxt = esect_pri_r | primary_sector_selects;
                  esect_sec_nxt = esect_sec_r | secondary_sector_selects;
               end
            end
            S_PROT_READ: begin
               state_nxt = (wdata == CMD_RESET) ? S_READ : S_PROT_READ; // R20
            end
            default: state_nxt = S_READ;
         endcase
      end
      if (timed_out && state_r == S_SECTOR_MORE) begin
         op_sel = OP_SERASE;
         launch = 1'b1; // R3 R12
      end
      if (state_r == S_PROT_READ && !timed_out && !flash_wr) begin
         state_nxt = S_PROT_READ; // R16
      end
   end

   assign op_sect_pri = (op_sel == OP_SERASE) ? esect_pri_r : primary_sector_selects;
   assign op_sect_sec = (op_sel == OP_SERASE) ? esect_sec_r : secondary_sector_selects;
   assign start_pri = launch && !tgt_r; // R8
   assign start_sec = launch && tgt_r; // R8

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_r <= S_READ; // R20
         tgt_r <= 1'b0;
         esect_pri_r <= '0;
         esect_sec_r <= '0;
      end else begin
         state_r <= state_nxt;
         tgt_r <= tgt_nxt;
         esect_pri_r <= esect_pri_nxt;
         esect_sec_r <= esect_sec_nxt;
      end
   end

   // gap counter restarts on every flash byte; protect read phase never times out
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         tmo_r <= '0;
      end else if (flash_wr || state_r == S_READ || state_r == S_PROT_READ) begin
         tmo_r <= '0; // R3
      end else if (!timed_out) begin
         tmo_r <= tmo_r + 1'b1;
      end
   end

   flash_array #(.NSECT(N_PRI), .SECT_W(PRI_W), .PROG_CYC(PROG_CYC),
                 .ERASE_CYC(ERASE_CYC)) u_pri (
      .clk(clk),
      .rst_n(rst_n),
      .sel(primary_sector_selects),
      .addr(addr[PRI_W-1:0]),
      .rdata(pri_rdata),
      .start(start_pri),
      .op(op_sel),
      .op_sect(op_sect_pri),
      .op_addr(addr[PRI_W-1:0]),
      .op_data(wdata),
      .suspend(susp_cmd && !tgt_now),
      .resume(resume_cmd && !tgt_now),
      .prot(pri_prot_cfg),
      .busy(pri_busy),
      .suspended(pri_susp),
      .poll_data(pri_poll)
   );

   flash_array #(.NSECT(N_SEC), .SECT_W(SEC_W), .PROG_CYC(PROG_CYC),
                 .ERASE_CYC(ERASE_CYC)) u_sec (
      .clk(clk),
      .rst_n(rst_n),
      .sel(secondary_sector_selects),
      .addr(addr[SEC_W-1:0]),
      .rdata(sec_rdata),
      .start(start_sec),
      .op(op_sel),
      .op_sect(op_sect_sec),
      .op_addr(addr[SEC_W-1:0]),
      .op_data(wdata),
      .suspend(susp_cmd && tgt_now),
      .resume(resume_cmd && tgt_now),
      .prot(sec_prot_cfg),
      .busy(sec_busy),
      .suspended(sec_susp),
      .poll_data(sec_poll)
   );

   flash_protect_regs u_regs (
      .clk(clk),
      .rst_n(rst_n),
      .window_rd(rd && register_window_select),
      .offset(addr[7:0]), // R18
      .pri_prot(pri_prot_cfg),
      .sec_prot(sec_prot_cfg),
      .security_bit(security_cfg),
      .rdata(reg_rdata),
      .hit(reg_hit)
   );

   // read path sources captured one cycle ahead of the data mux
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rd_d_r <= 1'b0;
         win_d_r <= 1'b0;
         prot_d_r <= 1'b0;
         poll_d_r <= 1'b0;
         tgt_d_r <= 1'b0;
         prot_byte_r <= '0;
         poll_byte_r <= '0;
      end else begin
         rd_d_r <= flash_rd || (rd && register_window_select);
         win_d_r <= reg_hit;
         prot_d_r <= flash_rd && state_r == S_PROT_READ
                     && addr[1:0] == PROT_READ_A10; // R16
         poll_d_r <= flash_rd && (tgt_now ? sec_busy && !sec_susp
                                          : pri_busy && !pri_susp); // R21
         tgt_d_r <= tgt_now;
         prot_byte_r <= ((primary_sector_selects & pri_prot_cfg) != '0
                         || (secondary_sector_selects & sec_prot_cfg) != '0)
                        ? PROT_YES : PROT_NO; // R19 R13
         poll_byte_r <= tgt_now ? sec_poll : pri_poll; // R21
      end
   end

   assign rvalid = rd_d_r;
   assign rdata = win_d_r ? reg_rdata :
                  prot_d_r ? prot_byte_r :
                  poll_d_r ? poll_byte_r :
                  tgt_d_r ? sec_rdata : pri_rdata; // R11
   // busy covers a suspended erase too; no write cycle is finished yet
   assign ready_busy_pin = !(pri_busy || sec_busy); // R1
endmodule
`default_nettype wire

// >>> rtl/flash_protect_regs.sv
// read-only protection registers in the register window
`timescale 1ns/1ns
`default_nettype none
module flash_protect_regs
   import flash_cmd_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic window_rd,
   input wire logic [7:0] offset,
   input wire logic [N_PRI-1:0] pri_prot,
   input wire logic [N_SEC-1:0] sec_prot,
   input wire logic security_bit,
   output logic [DATA_W-1:0] rdata,
   output logic hit
);
   logic is_pri;
   logic is_sec;
   assign is_pri = (offset == REG_PRI_PROT); // R17 R18
   assign is_sec = (offset == REG_SEC_PROT); // R17 R18
   assign hit = window_rd && (is_pri || is_sec);
   // writes to these offsets are simply not decoded
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rdata <= '0;
      end else if (window_rd) begin
         rdata <= is_pri ? DATA_W'(pri_prot) :
                  is_sec ? {security_bit, {(DATA_W-N_SEC-1){1'b0}}, sec_prot} : '0;
      end
   end
endmodule
`default_nettype wire

// >>> verification/flash_command_sequencer_tb.sv
// self-checking bench for the flash command sequencer
`timescale 1ns/1ns
`default_nettype none
module flash_command_sequencer_tb;
   import flash_cmd_pkg::*;
   localparam int TO = 20;
   localparam int PC = 10;
   localparam int EC = 300;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [N_PRI-1:0] pri_prot = '0;
   logic [N_SEC-1:0] sec_prot = '0;
   logic sec_bit = 1'b0;
   logic [ADDR_W-1:0] addr;
   logic [DATA_W-1:0] wdata, rdata, q;
   logic wr, rd, rvalid, rbp, win, v;
   logic [N_PRI-1:0] psel;
   logic [N_SEC-1:0] ssel;
   logic [7:0] mem [int];
   logic [31:0] rnd = 32'h5fc130a3;
   int n_fail = 0;
   int cmp_count = 0;
   always #10 clk = ~clk;
   mcu_bus_model i_mcu_bus_model (.clk(clk), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
      .pri_sel(psel), .sec_sel(ssel), .win_sel(win), .rdata(rdata), .rvalid(rvalid));
   flash_command_sequencer #(.TIMEOUT_CYC(TO), .PROG_CYC(PC), .ERASE_CYC(EC))
   i_flash_command_sequencer (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata),
      .wr(wr), .rd(rd), .primary_sector_selects(psel), .secondary_sector_selects(ssel),
      .register_window_select(win), .pri_prot_cfg(pri_prot), .sec_prot_cfg(sec_prot),
      .security_cfg(sec_bit), .rdata(rdata), .rvalid(rvalid), .ready_busy_pin(rbp));
   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction
   task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
      cmp_count++;
      if (s !== e) begin
         n_fail++;
         $display("mismatch %0s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic summarize();
      $display("checks %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   // negative k means the register window, no sector select
   task automatic bus(input logic r, input logic [15:0] a, input logic [7:0] d, input int k);
      i_mcu_bus_model.xfer(r, a, d, (k < 0) ? 6'h00 : 6'(1 << k), k < 0, q, v);
   endtask
   task automatic rdchk(input string n, input int k, input logic [15:0] a, input logic [7:0] e);
      bus(1'b1, a, 8'h00, k);
      chk({n, " valid"}, {7'h0, v}, 8'h01);
      chk(n, q, e);
   endtask
   task automatic wt(input logic want, input int lim);
      int i;
      i = 0;
      while (rbp !== want && i < lim) begin
         @(posedge clk);
         #1;
         i++;
      end
      chk("ready busy", {7'h0, rbp}, {7'h0, want});
   endtask
   // model: erase covers only the low bytes, kept small against the short erase count
   task automatic wipe(input int lo, input int hi);
      for (int k = lo; k <= hi; k++) begin
         for (int o = 0; o < 8; o++) begin
            mem[k * 256 + o] = ERASED_BYTE;
         end
      end
   endtask
   task automatic verify();
      foreach (mem[key]) rdchk("flash byte", key / 256, 16'(key % 256), mem[key]);
   endtask
   task automatic prog(input int k, input logic [7:0] off, input logic [7:0] d, input logic ok);
      i_mcu_bus_model.cmd(CMD_PROGRAM, 6'(1 << k));
      bus(1'b0, {8'h00, off}, d, k);
      if (ok) begin
         bus(1'b1, {8'h00, off}, 8'h00, k);
         chk("poll bit", {7'h0, q[POLL_BIT]}, {7'h0, ~d[POLL_BIT]});
         chk("busy", {7'h0, rbp}, 8'h00);
         wt(1'b1, PC + 20);
         mem[k * 256 + off] = mem[k * 256 + off] & d;
      end else begin
         repeat (PC) @(negedge clk);
         chk("refused", {7'h0, rbp}, 8'h01);
      end
   endtask
   task automatic chip_erase(input int k, input int lo, input int hi);
      i_mcu_bus_model.cmd(CMD_ERASE_SETUP, 6'(1 << k));
      i_mcu_bus_model.cmd(CMD_CHIP_ERASE, 6'(1 << k));
      wt(1'b0, 20);
      wt(1'b1, 8 * EC);
      wipe(lo, hi);
   endtask
   initial begin
      #(20 * 50000);
      n_fail++;
      summarize();
   end
   initial begin
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      #1;
      chk("ready after reset", {7'h0, rbp}, 8'h01);
      for (int i = 0; i < 3; i++) begin
         @(posedge clk);
         rnd = lfsr(rnd);
         pri_prot <= rnd[3:0];
         sec_prot <= rnd[5:4];
         sec_bit <= rnd[6];
         rdchk("c0", -1, {8'h7f, REG_PRI_PROT}, {4'h0, rnd[3:0]});
         rdchk("c2", -1, {8'h3e, REG_SEC_PROT}, {rnd[6], 5'h00, rnd[5:4]});
      end
      bus(1'b1, 16'h7fc4, 8'h00, -1);
      chk("unmapped valid", {7'h0, v}, 8'h01);
      @(posedge clk);
      pri_prot <= '0;
      sec_prot <= '0;
      $display("test registers done");
      chip_erase(0, 0, 3);
      for (int i = 0; i < 4; i++) begin
         rnd = lfsr(rnd);
         prog(0, 8'(i), rnd[7:0], 1'b1);
      end
      bus(1'b0, 16'h0004, 8'h00, 0);
      repeat (PC) @(negedge clk);
      chk("lone write", {7'h0, rbp}, 8'h01);
      verify();
      $display("test program done");
      bus(1'b0, 16'h5555, 8'haa, 0);
      bus(1'b0, 16'h0aaa, 8'h55, 0);
      bus(1'b0, 16'h0555, 8'h77, 0);
      bus(1'b0, 16'h0005, 8'h00, 0);
      repeat (PC) @(negedge clk);
      chk("bad byte", {7'h0, rbp}, 8'h01);
      i_mcu_bus_model.cmd(CMD_PROGRAM, 6'h01);
      repeat (TO + 5) @(posedge clk);
      bus(1'b0, 16'h0005, 8'h00, 0);
      repeat (PC) @(negedge clk);
      chk("gap too long", {7'h0, rbp}, 8'h01);
      verify();
      $display("test abort done");
      @(posedge clk);
      pri_prot <= 4'b0010;
      i_mcu_bus_model.cmd(CMD_PROT_READ, 6'h02);
      rdchk("prot set", 1, 16'h0002, PROT_YES);
      rdchk("prot again", 1, 16'h1002, PROT_YES);
      rdchk("prot clear", 0, 16'h0002, PROT_NO);
      bus(1'b0, 16'h0000, CMD_RESET, 0);
      rdchk("read mode", 0, 16'h0000, mem[0]);
      prog(1, 8'h02, 8'h00, 1'b0);
      @(posedge clk);
      pri_prot <= '0;
      $display("test protect done");
      prog(1, 8'h00, 8'h3c, 1'b1);
      i_mcu_bus_model.cmd(CMD_ERASE_SETUP, 6'h02);
      i_mcu_bus_model.cmd(CMD_SECTOR_ERASE, 6'h02);
      wt(1'b0, TO + 20);
      bus(1'b0, 16'h0000, CMD_SUSPEND, 1);
      repeat (5) @(negedge clk);
      chk("suspended busy", {7'h0, rbp}, 8'h00);
      rdchk("read in suspend", 0, 16'h0000, mem[0]);
      bus(1'b0, 16'h0000, CMD_RESUME, 1);
      wt(1'b1, 2 * EC);
      wipe(1, 1);
      verify();
      $display("test sector erase done");
      chip_erase(4, 4, 5);
      rnd = lfsr(rnd);
      prog(4, 8'h01, rnd[7:0], 1'b1);
      verify();
      $display("test secondary done");
      summarize();
   end
endmodule
`default_nettype wire

// >>> verification/flash_seq_props.sv
// port assertions for the flash command sequencer
`timescale 1ns/1ns
`default_nettype none
module flash_seq_props
   import flash_cmd_pkg::*;
#(
   parameter int TIMEOUT_CYC = TIMEOUT_CYC_DEF,
   parameter int PROG_CYC = PROG_CYC_DEF,
   parameter int ERASE_CYC = ERASE_CYC_DEF
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [ADDR_W-1:0] addr,
   input wire logic [DATA_W-1:0] wdata,
   input wire logic wr,
   input wire logic rd,
   input wire logic [N_PRI-1:0] primary_sector_selects,
   input wire logic [N_SEC-1:0] secondary_sector_selects,
   input wire logic register_window_select,
   input wire logic [N_PRI-1:0] pri_prot_cfg,
   input wire logic [N_SEC-1:0] sec_prot_cfg,
   input wire logic security_cfg,
   input wire logic [DATA_W-1:0] rdata,
   input wire logic rvalid,
   input wire logic ready_busy_pin
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   logic [15:0] since_wr_r;
   logic [15:0] low_cnt_r;
   wire [15:0] since_wr_nxt;
   wire [15:0] low_cnt_nxt;
   wire any_sel;
   // saturate so a long idle never wraps into a false short gap
   assign since_wr_nxt = wr ? 16'h0000 : since_wr_r + {15'h0000, since_wr_r != 16'hffff};
   assign low_cnt_nxt = ready_busy_pin ? 16'h0000 : low_cnt_r + {15'h0000, low_cnt_r != 16'hffff};
   assign any_sel = (|primary_sector_selects) || (|secondary_sector_selects);
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         since_wr_r <= 16'hffff;
         low_cnt_r <= 16'h0000;
      end else begin
         since_wr_r <= since_wr_nxt;
         low_cnt_r <= low_cnt_nxt;
      end
   end
   rd_answer_a: assert property (rd && (any_sel || register_window_select) |=> rvalid)
      else $error("read not answered");
   rv_cause_a: assert property (rvalid |-> $past(rd) && ($past(any_sel) || $past(register_window_select)))
      else $error("answer without read");
   reg_pri_a: assert property (rd && register_window_select && !any_sel && addr[7:0] == REG_PRI_PROT
      |=> rdata == {4'h0, $past(pri_prot_cfg)}) else $error("primary protect register wrong");
   reg_sec_a: assert property (rd && register_window_select && !any_sel && addr[7:0] == REG_SEC_PROT
      |=> rdata == {$past(security_cfg), 5'h00, $past(sec_prot_cfg)}) else $error("secondary register wrong");
   wr_silent_a: assert property (wr && !rd |=> !rvalid)
      else $error("write produced read data");
   reset_ready_a: assert property ($rose(rst_n) |-> ready_busy_pin)
      else $error("busy right after reset");
   launch_cause_a: assert property ($fell(ready_busy_pin) |-> since_wr_r <= TIMEOUT_CYC + 3)
      else $error("operation started without recent command");
   busy_min_a: assert property ($rose(ready_busy_pin) |-> low_cnt_r >= PROG_CYC)
      else $error("busy too short");
endmodule
bind flash_command_sequencer flash_seq_props #(
   .TIMEOUT_CYC(TIMEOUT_CYC), .PROG_CYC(PROG_CYC), .ERASE_CYC(ERASE_CYC)
) i_flash_seq_props (
   .clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
   .primary_sector_selects(primary_sector_selects),
   .secondary_sector_selects(secondary_sector_selects),
   .register_window_select(register_window_select), .pri_prot_cfg(pri_prot_cfg),
   .sec_prot_cfg(sec_prot_cfg), .security_cfg(security_cfg), .rdata(rdata),
   .rvalid(rvalid), .ready_busy_pin(ready_busy_pin)
);
`default_nettype wire

// >>> verification/mcu_bus_model.sv
// bus master model of the controlling processor
`timescale 1ns/1ns
`default_nettype none
module mcu_bus_model
   import flash_cmd_pkg::*;
(
   input wire logic clk,
   output logic [ADDR_W-1:0] addr,
   output logic [DATA_W-1:0] wdata,
   output logic wr,
   output logic rd,
   output logic [N_PRI-1:0] pri_sel,
   output logic [N_SEC-1:0] sec_sel,
   output logic win_sel,
   input wire logic [DATA_W-1:0] rdata,
   input wire logic rvalid
);
   initial begin
      addr = '0;
      wdata = '0;
      wr = 1'b0;
      rd = 1'b0;
      pri_sel = '0;
      sec_sel = '0;
      win_sel = 1'b0;
   end
   // selects ride with the strobe, else the array never sees the byte
   task automatic xfer(input logic r, input logic [15:0] a, input logic [7:0] d,
         input logic [5:0] s, input logic w, output logic [7:0] q, output logic v);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= !r;
      rd <= r;
      {sec_sel, pri_sel} <= s;
      win_sel <= w;
      @(posedge clk);
      wr <= 1'b0;
      rd <= 1'b0;
      {sec_sel, pri_sel} <= '0;
      win_sel <= 1'b0;
      wdata <= ~d;
      #1;
      q = rdata;
      v = rvalid;
   endtask
   // upper address nibble varies, only the low bits should match
   task automatic cmd(input logic [7:0] c, input logic [5:0] s);
      logic [7:0] q;
      logic v;
      xfer(1'b0, 16'h5555, UNLOCK1_DATA, s, 1'b0, q, v);
      xfer(1'b0, 16'hfaaa, UNLOCK2_DATA, s, 1'b0, q, v);
      xfer(1'b0, 16'h9555, c, s, 1'b0, q, v);
   endtask
endmodule
`default_nettype wire
